/* src/mmd_decoder.sv */
`timescale 1ns/100ps
`include "mmd_map.svh"
// How it works
// - Strobe code fetches once per six-clock period, skip data
// - Program strobe high during internal execution
// - Program strobe low at reset: serial download
// - Address latch pulses once per external bus cycle, none while data moves
// - Power control bit four disables address latch
// - Low port drives address/data strongly on bus
// - Low port ones float in general use
// - External-access input picks code space at reset
// - Internal fetches F800h-FFFFh return no-ops
// - Upper RAM half indirect only, direct hits SFRs
// - Lowest 32 bytes: four eight-register banks
// - Bytes 20h-2Fh carry bit addresses 00h-7Fh
// - Stack pointer resets to 07h
// - Push increments pointer before writing
// - Config bit zero maps on-chip extended RAM
// - Pointers above 0007FFh always go off-chip
// - On-chip extended RAM accesses leave pins idle
// - Without extension stack wraps FFh to 00h
// - Extension continues FFh to 0100h, 11 bits
// - Upper 1792 extended bytes serve as stack
// - High pointer bits usable only when extended
// - High port carries upper address bytes externally
module mmd_decoder
    import mmd_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic external_access_select,
    input wire logic program_store_strobe_in,
    input wire logic power_control_we,
    input wire logic [7:0] power_control_wdata,
    input wire logic memory_config_we,
    input wire logic [7:0] memory_config_wdata,
    input wire logic code_req,
    input wire logic [15:0] code_addr,
    input wire logic data_req,
    input wire logic data_we,
    input wire logic [23:0] data_pointer_reg,
    input wire logic [7:0] data_wdata,
    input wire logic [7:0] low_port_in,
    input wire logic [7:0] low_port_latch,
    input wire logic [7:0] high_port_latch,
    input wire logic ram_req,
    input wire mmd_pkg::mmd_ram_mode_type ram_mode,
    input wire logic [7:0] ram_operand,
    input wire logic [1:0] bank_select,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic stack_top_pointer_we,
    input wire logic [7:0] stack_top_pointer_wdata,
    input wire logic stack_pointer_high_we,
    input wire logic [7:0] stack_pointer_high_wdata,
    output logic program_store_strobe_n,
    output logic addr_latch_strobe,
    output logic [7:0] low_port_out,
    output logic [7:0] low_port_oe,
    output logic [7:0] high_port_out,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic serial_download_mode,
    output logic exec_external,
    output logic startup_done,
    output logic code_valid,
    output logic code_from_flash,
    output logic [7:0] code_data,
    output logic data_valid,
    output logic data_onchip,
    output logic [10:0] data_onchip_addr,
    output logic [7:0] data_rdata,
    output logic [7:0] power_control_reg,
    output logic [7:0] memory_config_reg,
    output logic ram_valid,
    output logic ram_to_sfr,
    output logic [7:0] ram_addr,
    output logic [2:0] ram_bit_pos,
    output logic [7:0] stack_top_pointer,
    output logic [7:0] stack_pointer_high,
    output logic [10:0] stack_addr,
    output logic stack_in_extended_data_ram
);
    import mmd_pkg::*;

    // Configuration and reset straps
    logic strap_done_r, strap_done_nxt;
    logic dl_mode_r, dl_mode_nxt;
    logic ext_exec_r, ext_exec_nxt;
    logic [7:0] power_control_reg_r, power_control_reg_nxt;
    logic [7:0] mcfg_r, mcfg_nxt;

    always_comb begin
        strap_done_nxt = 1'b1;
        dl_mode_nxt = dl_mode_r;
        ext_exec_nxt = ext_exec_r;
        power_control_reg_nxt = power_control_reg_r;
        mcfg_nxt = mcfg_r;
        // Straps caught on the first edge after release, never by the reset itself
        if (!strap_done_r) begin
            dl_mode_nxt = !program_store_strobe_in;
            ext_exec_nxt = !external_access_select;
        end
        if (power_control_we) begin
            power_control_reg_nxt = power_control_wdata;
        end
        if (memory_config_we) begin
            mcfg_nxt = memory_config_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_done_r <= 1'b0;
            dl_mode_r <= 1'b0;
            ext_exec_r <= 1'b0;
            power_control_reg_r <= `MMD_POWER_CONTROL_REG_RESET;
            mcfg_r <= `MMD_CFG_RESET;
        end else begin
            strap_done_r <= strap_done_nxt;
            dl_mode_r <= dl_mode_nxt;
            ext_exec_r <= ext_exec_nxt;
            power_control_reg_r <= power_control_reg_nxt;
            mcfg_r <= mcfg_nxt;
        end
    end

    wire logic exstack = mcfg_r[`MMD_CFG_EXSTACK];
    wire logic extended_data_ram_en = mcfg_r[`MMD_CFG_ONCHIP_EXTRAM_ENABLE];
    wire logic ale_off = power_control_reg_r[`MMD_POWER_CONTROL_REG_ALEOFF];

    // External bus sequencer; one bus period is six clocks
    mmd_bus_state_type st_r, st_nxt;
    logic [2:0] ph_r, ph_nxt;
    logic [15:0] ca_r, ca_nxt;
    logic [23:0] da_r, da_nxt;
    logic [7:0] wd_r, wd_nxt;
    logic we_r, we_nxt;
    logic program_store_strobe_n_r, program_store_strobe_n_nxt;
    logic ale_r, ale_nxt;
    logic [7:0] lp_out_r, lp_out_nxt;
    logic [7:0] lp_oe_r, lp_oe_nxt;
    logic [7:0] hp_r, hp_nxt;
    logic rd_n_r, rd_n_nxt;
    logic wr_n_r, wr_n_nxt;
    logic cv_r, cv_nxt;
    logic cf_r, cf_nxt;
    logic [7:0] cd_r, cd_nxt;
    logic dv_r, dv_nxt;
    logic don_r, don_nxt;
    logic [10:0] doa_r, doa_nxt;
    logic [7:0] drd_r, drd_nxt;
    logic onchip_hit;
    logic strobe_win;

    always_comb begin
        st_nxt = st_r;
        ph_nxt = (ph_r == `MMD_PH_LAST) ? 3'h0 : ph_r + 3'h1;
        ca_nxt = ca_r;
        da_nxt = da_r;
        wd_nxt = wd_r;
        we_nxt = we_r;
        cv_nxt = 1'b0;
        cf_nxt = 1'b0;
        cd_nxt = cd_r;
        dv_nxt = 1'b0;
        don_nxt = 1'b0;
        doa_nxt = doa_r;
        drd_nxt = drd_r;
        program_store_strobe_n_nxt = 1'b1;
        ale_nxt = 1'b0;
        rd_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
        lp_out_nxt = 8'h00;
        lp_oe_nxt = ~low_port_latch;
        hp_nxt = high_port_latch;
        onchip_hit = extended_data_ram_en && (data_pointer_reg <= `MMD_EXTENDED_DATA_RAM_TOP);
        strobe_win = (ph_r >= `MMD_PH_STB_ON) && (ph_r < `MMD_PH_STB_OFF);
        case (st_r)
            MMD_BUS_IDLE: begin
                // On-chip extended RAM answers at once and leaves the pins alone
                if (data_req && !dv_r && strap_done_r && onchip_hit) begin
                    dv_nxt = 1'b1;
                    don_nxt = 1'b1;
                    doa_nxt = data_pointer_reg[10:0];
                end else if (data_req && !dv_r && strap_done_r && ph_r == `MMD_PH_LAST) begin
                    st_nxt = MMD_BUS_DADDR;
                    da_nxt = data_pointer_reg;
                    wd_nxt = data_wdata;
                    we_nxt = data_we;
                end else if (code_req && !cv_r && strap_done_r && !ext_exec_r) begin
                    // Internal flash; the top 2 kB never fall through to the bus
                    cv_nxt = 1'b1;
                    cf_nxt = (code_addr < `MMD_NOP_BASE);
                    cd_nxt = `MMD_NOP_OPCODE;
                end else if (code_req && !cv_r && strap_done_r && ph_r == `MMD_PH_LAST) begin
                    st_nxt = MMD_BUS_FETCH;
                    ca_nxt = code_addr;
                end
            end
            MMD_BUS_FETCH: begin
                ale_nxt = (ph_r == 3'h0) && !ale_off;
                hp_nxt = ca_r[15:8];
                if (ph_r <= `MMD_PH_ADDR_END) begin
                    lp_out_nxt = ca_r[7:0];
                    lp_oe_nxt = 8'hff;
                end else begin
                    lp_oe_nxt = 8'h00;
                end
                program_store_strobe_n_nxt = (ph_r < `MMD_PH_PROGRAM_STORE_STROBE_ON);
                if (ph_r == `MMD_PH_LAST) begin
                    st_nxt = MMD_BUS_IDLE;
                    cv_nxt = 1'b1;
                    cd_nxt = low_port_in;
                end
            end
            MMD_BUS_DADDR: begin
                // Latch pulse carries the address, then the periodic ones stop
                ale_nxt = (ph_r == 3'h0) && !ale_off;
                lp_oe_nxt = 8'hff;
                lp_out_nxt = (ph_r <= `MMD_PH_ADDR_END) ? da_r[7:0] : wd_r;
                hp_nxt = (ph_r <= `MMD_PH_ADDR_END) ? da_r[23:16] : da_r[15:8];
                if (!we_r && ph_r > `MMD_PH_ADDR_END) begin
                    lp_oe_nxt = 8'h00;
                end
                if (ph_r == `MMD_PH_LAST) begin
                    st_nxt = MMD_BUS_DSTROBE;
                end
            end
            MMD_BUS_DSTROBE: begin
                // No latch and no program strobe while data moves
                hp_nxt = da_r[15:8];
                lp_out_nxt = wd_r;
                lp_oe_nxt = we_r ? 8'hff : 8'h00;
                rd_n_nxt = !(strobe_win && !we_r);
                wr_n_nxt = !(strobe_win && we_r);
                if (ph_r == `MMD_PH_STB_OFF && !we_r) begin
                    drd_nxt = low_port_in;
                end
                if (ph_r == `MMD_PH_LAST) begin
                    st_nxt = MMD_BUS_IDLE;
                    dv_nxt = 1'b1;
                end
            end
            default: begin
                st_nxt = MMD_BUS_IDLE;
            end
        endcase
        if (!ext_exec_r) begin
            program_store_strobe_n_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= MMD_BUS_IDLE;
            ph_r <= 3'h0;
            ca_r <= 16'h0000;
            da_r <= 24'h000000;
            wd_r <= 8'h00;
            we_r <= 1'b0;
            program_store_strobe_n_r <= 1'b1;
            ale_r <= 1'b0;
            lp_out_r <= 8'h00;
            lp_oe_r <= 8'h00;
            hp_r <= 8'hff;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            cv_r <= 1'b0;
            cf_r <= 1'b0;
            cd_r <= 8'h00;
            dv_r <= 1'b0;
            don_r <= 1'b0;
            doa_r <= 11'h000;
            drd_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            ph_r <= ph_nxt;
            ca_r <= ca_nxt;
            da_r <= da_nxt;
            wd_r <= wd_nxt;
            we_r <= we_nxt;
            program_store_strobe_n_r <= program_store_strobe_n_nxt;
            ale_r <= ale_nxt;
            lp_out_r <= lp_out_nxt;
            lp_oe_r <= lp_oe_nxt;
            hp_r <= hp_nxt;
            rd_n_r <= rd_n_nxt;
            wr_n_r <= wr_n_nxt;
            cv_r <= cv_nxt;
            cf_r <= cf_nxt;
            cd_r <= cd_nxt;
            dv_r <= dv_nxt;
            don_r <= don_nxt;
            doa_r <= doa_nxt;
            drd_r <= drd_nxt;
        end
    end

    // General RAM address decode
    logic rv_r, rv_nxt;
    logic sfr_r, sfr_nxt;
    logic [7:0] ra_r, ra_nxt;
    logic [2:0] rb_r, rb_nxt;

    always_comb begin
        rv_nxt = ram_req;
        sfr_nxt = 1'b0;
        ra_nxt = ram_operand;
        rb_nxt = 3'h0;
        case (ram_mode)
            MMD_RAM_DIRECT: begin
                sfr_nxt = ram_operand[`MMD_SFR_BIT];
            end
            MMD_RAM_INDIRECT: begin
                sfr_nxt = 1'b0;
            end
            MMD_RAM_BANKREG: begin
                ra_nxt = {3'h0, bank_select, ram_operand[2:0]};
            end
            MMD_RAM_BIT: begin
                // Upper bit space belongs to SFRs
                sfr_nxt = ram_operand[`MMD_SFR_BIT];
                ra_nxt = {`MMD_BITRAM_BASE, ram_operand[6:3]};
                rb_nxt = ram_operand[2:0];
            end
            default: begin
                ra_nxt = ram_operand;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rv_r <= 1'b0;
            sfr_r <= 1'b0;
            ra_r <= 8'h00;
            rb_r <= 3'h0;
        end else begin
            rv_r <= rv_nxt;
            sfr_r <= sfr_nxt;
            ra_r <= ra_nxt;
            rb_r <= rb_nxt;
        end
    end

    // Stack pointer, 8 or 11 bits
    logic [7:0] sp_r, sp_nxt;
    logic [2:0] sph_r, sph_nxt;
    logic [10:0] sa_r, sa_nxt;
    logic sx_r, sx_nxt;
    logic [10:0] ptr, ptr_inc, ptr_dec;

    always_comb begin
        ptr = {sph_r, sp_r};
        ptr_inc = exstack ? ptr + 11'h001 : {3'h0, sp_r + 8'h01};
        ptr_dec = exstack ? ptr - 11'h001 : {3'h0, sp_r - 8'h01};
        sp_nxt = sp_r;
        sph_nxt = exstack ? sph_r : 3'h0;
        sa_nxt = sa_r;
        if (stack_push) begin
            sp_nxt = ptr_inc[7:0];
            sph_nxt = ptr_inc[10:8];
            sa_nxt = ptr_inc;
        end else if (stack_pop) begin
            sp_nxt = ptr_dec[7:0];
            sph_nxt = ptr_dec[10:8];
            sa_nxt = ptr;
        end
        if (stack_top_pointer_we) begin
            sp_nxt = stack_top_pointer_wdata;
        end
        if (stack_pointer_high_we && exstack) begin
            sph_nxt = stack_pointer_high_wdata[2:0];
        end
        // Clear with the enable itself, so no stale high bits show for a cycle
        if (!mcfg_nxt[`MMD_CFG_EXSTACK]) begin
            sph_nxt = 3'h0;
        end
        sx_nxt = (sa_nxt[10:8] != 3'h0);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sp_r <= `MMD_SP_RESET;
            sph_r <= 3'h0;
            sa_r <= 11'h000;
            sx_r <= 1'b0;
        end else begin
            sp_r <= sp_nxt;
            sph_r <= sph_nxt;
            sa_r <= sa_nxt;
            sx_r <= sx_nxt;
        end
    end

    assign program_store_strobe_n = program_store_strobe_n_r;
    assign addr_latch_strobe = ale_r;
    assign low_port_out = lp_out_r;
    assign low_port_oe = lp_oe_r;
    assign high_port_out = hp_r;
    assign read_strobe_n = rd_n_r;
    assign write_strobe_n = wr_n_r;
    assign serial_download_mode = dl_mode_r;
    assign exec_external = ext_exec_r;
    assign startup_done = strap_done_r;
    assign code_valid = cv_r;
    assign code_from_flash = cf_r;
    assign code_data = cd_r;
    assign data_valid = dv_r;
    assign data_onchip = don_r;
    assign data_onchip_addr = doa_r;
    assign data_rdata = drd_r;
    assign power_control_reg = power_control_reg_r;
    assign memory_config_reg = mcfg_r;
    assign ram_valid = rv_r;
    assign ram_to_sfr = sfr_r;
    assign ram_addr = ra_r;
    assign ram_bit_pos = rb_r;
    assign stack_top_pointer = sp_r;
    // High pointer reads as zero unless the extension is on
    assign stack_pointer_high = {5'h00, sph_r};
    assign stack_addr = sa_r;
    assign stack_in_extended_data_ram = sx_r;
endmodule

/* src/mmd_map.svh */
`ifndef MMD_MAP_SVH
`define MMD_MAP_SVH
`define MMD_PH_LAST 3'h5
`define MMD_PH_ADDR_END 3'h1
`define MMD_PH_PROGRAM_STORE_STROBE_ON 3'h3
`define MMD_PH_STB_ON 3'h1
`define MMD_PH_STB_OFF 3'h4
`define MMD_NOP_OPCODE 8'h00
`define MMD_NOP_BASE 16'hf800
`define MMD_EXTENDED_DATA_RAM_TOP 24'h0007ff
`define MMD_SP_RESET 8'h07
`define MMD_CFG_RESET 8'h00
`define MMD_POWER_CONTROL_REG_RESET 8'h00
`define MMD_POWER_CONTROL_REG_ALEOFF 4
`define MMD_CFG_EXSTACK 7
`define MMD_CFG_ONCHIP_EXTRAM_ENABLE 0
`define MMD_SFR_BIT 7
`define MMD_BITRAM_BASE 4'h2
`endif

/* src/mmd_pkg.sv */
package mmd_pkg;
    typedef enum logic [1:0] {
        MMD_BUS_IDLE, MMD_BUS_FETCH, MMD_BUS_DADDR, MMD_BUS_DSTROBE
    } mmd_bus_state_type;
    typedef enum logic [1:0] {
        MMD_RAM_DIRECT, MMD_RAM_INDIRECT, MMD_RAM_BANKREG, MMD_RAM_BIT
    } mmd_ram_mode_type;
endpackage

/* tb/mmd_decoder_chk.sv */
`timescale 1ns/100ps
module mmd_decoder_chk
    import mmd_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] code_addr,
    input wire logic [23:0] data_pointer_reg,
    input wire logic data_req,
    input wire logic ram_req,
    input wire mmd_pkg::mmd_ram_mode_type ram_mode,
    input wire logic [7:0] ram_operand,
    input wire logic stack_push,
    input wire logic stack_top_pointer_we,
    input wire logic program_store_strobe_n,
    input wire logic addr_latch_strobe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic exec_external,
    input wire logic startup_done,
    input wire logic code_valid,
    input wire logic code_from_flash,
    input wire logic [7:0] code_data,
    input wire logic data_valid,
    input wire logic data_onchip,
    input wire logic [7:0] power_control_reg,
    input wire logic [7:0] memory_config_reg,
    input wire logic ram_valid,
    input wire logic ram_to_sfr,
    input wire logic [7:0] stack_top_pointer,
    input wire logic [7:0] stack_pointer_high
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_program_store_strobe_internal: assert property (startup_done && !exec_external |-> program_store_strobe_n)
        else $error("program strobe active in internal mode");
    chk_program_store_strobe_width: assert property ($fell(program_store_strobe_n) |->
        !program_store_strobe_n [*3] ##1 program_store_strobe_n) else $error("program strobe width");
    chk_program_store_strobe_data_excl: assert property (!program_store_strobe_n |-> read_strobe_n && write_strobe_n)
        else $error("program strobe during data access");
    chk_ale_spacing: assert property ($rose(addr_latch_strobe) |=> !addr_latch_strobe [*5])
        else $error("latch strobe spacing");
    chk_ale_disabled: assert property (power_control_reg[4] |-> !addr_latch_strobe)
        else $error("latch strobe while disabled");
    chk_nop_region: assert property (code_valid && !exec_external && code_addr >= 16'hf800 |->
        code_data == 8'h00 && !code_from_flash) else $error("no-op region fetch");
    chk_ram_direct: assert property (ram_req && ram_mode == MMD_RAM_DIRECT |=>
        ram_valid && ram_to_sfr == $past(ram_operand[7])) else $error("direct ram decode");
    chk_sp_reset: assert property ($rose(startup_done) |-> stack_top_pointer == 8'h07)
        else $error("stack pointer reset value");
    chk_push_wrap: assert property (stack_push && !stack_top_pointer_we && !memory_config_reg[7] |=>
        stack_top_pointer == $past(stack_top_pointer) + 8'h01) else $error("push increment");
    chk_data_map: assert property (data_valid |->
        data_onchip == (memory_config_reg[0] && data_pointer_reg <= 24'h0007ff)) else $error("data map");
    chk_onchip_quiet: assert property (data_req && memory_config_reg[0] &&
        data_pointer_reg <= 24'h0007ff |-> read_strobe_n && write_strobe_n) else $error("strobe on chip");
    chk_sph_locked: assert property (!memory_config_reg[7] |-> stack_pointer_high == 8'h00)
        else $error("stack high visible");
    cover property (data_valid && data_onchip);
    cover property (!read_strobe_n);
    cover property (code_valid && exec_external);
endmodule
bind mmd_decoder mmd_decoder_chk u_chk (.*);

/* tb/mmd_ext_mem.sv */
`timescale 1ns/100ps
module mmd_ext_mem (
    input wire logic clk,
    input wire logic addr_latch_strobe,
    input wire logic program_store_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] low_port_out,
    input wire logic [7:0] low_port_oe,
    input wire logic [7:0] high_port_out,
    output logic [7:0] low_port_pins
);
    logic [7:0] lo = 8'h00, page = 8'h00, wr_data = 8'h00;
    logic [23:0] wr_addr = 24'h000000;
    function automatic logic [7:0] pat(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'ha5;
    endfunction
    // Code fetches carry no page byte
    wire logic [7:0] rd = pat({program_store_strobe_n ? page : 8'h00, high_port_out, lo});
    wire logic drv = !program_store_strobe_n || !read_strobe_n;
    // Released pins fall to the external pull-up
    assign low_port_pins = (low_port_oe & low_port_out) | (~low_port_oe & (drv ? rd : 8'hff));
    always @(posedge clk) begin
        if (addr_latch_strobe) begin
            lo <= low_port_out;
            page <= high_port_out;
        end
        // Last strobe cycle wins, as a real part latches at the rising edge
        if (!write_strobe_n) begin
            wr_addr <= {page, high_port_out, lo};
            wr_data <= low_port_out;
        end
    end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    import mmd_pkg::*;
    logic clk = 1'h0, reset_n = 1'h0, external_access_select = 1'h1, program_store_strobe_in = 1'h1;
    logic power_control_we = 1'h0, memory_config_we = 1'h0, code_req = 1'h0, data_req = 1'h0;
    logic data_we = 1'h0, ram_req = 1'h0, stack_push = 1'h0, stack_pop = 1'h0;
    logic stack_top_pointer_we = 1'h0, stack_pointer_high_we = 1'h0;
    logic [7:0] power_control_wdata = 8'h00, memory_config_wdata = 8'h00, data_wdata = 8'h00;
    logic [7:0] low_port_latch = 8'hff, high_port_latch = 8'hff, ram_operand = 8'h00;
    logic [7:0] stack_top_pointer_wdata = 8'h00, stack_pointer_high_wdata = 8'h00;
    logic [15:0] code_addr = 16'h0000;
    logic [23:0] data_pointer_reg = 24'h000000;
    logic [1:0] bank_select = 2'h0;
    mmd_ram_mode_type ram_mode = MMD_RAM_DIRECT;
    logic [7:0] low_port_in, low_port_out, low_port_oe, high_port_out, code_data, data_rdata;
    logic [7:0] power_control_reg, memory_config_reg, ram_addr, stack_top_pointer, stack_pointer_high;
    logic program_store_strobe_n, addr_latch_strobe, read_strobe_n, write_strobe_n, exec_external;
    logic serial_download_mode, startup_done, code_valid, code_from_flash, data_valid, data_onchip;
    logic ram_valid, ram_to_sfr, stack_in_extended_data_ram;
    logic [10:0] data_onchip_addr, stack_addr;
    logic [2:0] ram_bit_pos;
    logic [7:0] d;
    logic f;
    int miscompares = 0, comparisons = 0, ale_cnt = 0, c0;

    always #25 clk = ~clk;
    always @(posedge clk) if (addr_latch_strobe === 1'h1) ale_cnt <= ale_cnt + 1;

    mmd_decoder dut (.*);
    mmd_ext_mem mem (.clk, .addr_latch_strobe, .program_store_strobe_n, .read_strobe_n,
        .write_strobe_n, .low_port_out, .low_port_oe, .high_port_out, .low_port_pins(low_port_in));

    function automatic logic [7:0] pat(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'ha5;
    endfunction
    task chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task print_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task do_reset(input logic ea, input logic ps);
        @(posedge clk) reset_n <= 1'h0;
        external_access_select <= ea;
        program_store_strobe_in <= ps;
        repeat (2) @(posedge clk);
        reset_n <= 1'h1;
        repeat (2) @(posedge clk);
        program_store_strobe_in <= 1'h1;
        @(negedge clk);
    endtask
    task code_rd(input logic [15:0] a);
        int n;
        n = 0;
        @(posedge clk) code_req <= 1'h1;
        code_addr <= a;
        do @(negedge clk); while (code_valid !== 1'h1 && ++n < 40);
        chk("code_valid", 1, code_valid);
        d = code_data;
        f = code_from_flash;
        @(posedge clk) code_req <= 1'h0;
    endtask
    task data_acc(input logic we, input logic [23:0] a, input logic [7:0] wd, input logic on);
        int n;
        n = 0;
        c0 = ale_cnt;
        @(posedge clk) data_req <= 1'h1;
        data_we <= we;
        data_pointer_reg <= a;
        data_wdata <= wd;
        do @(negedge clk); while (data_valid !== 1'h1 && ++n < 60);
        chk("data_onchip", on, data_onchip);
        if (on) chk("onchip_addr", a[10:0], data_onchip_addr);
        else chk("ale_pulses", 1, ale_cnt - c0);
        if (!on && !we) chk("data_rdata", pat(a), data_rdata);
        @(posedge clk) data_req <= 1'h0;
    endtask
    task ram_chk(input mmd_ram_mode_type m, input logic [7:0] op, input logic [1:0] b,
            input logic [7:0] ea, input logic s, input logic [2:0] bp);
        @(posedge clk) ram_req <= 1'h1;
        ram_mode <= m;
        ram_operand <= op;
        bank_select <= b;
        @(posedge clk) ram_req <= 1'h0;
        @(negedge clk);
        chk("ram_to_sfr", s, ram_to_sfr);
        if (!s) chk("ram_addr", ea, ram_addr);
        if (m == MMD_RAM_BIT) chk("ram_bit_pos", bp, ram_bit_pos);
    endtask
    task cfg_wr(input logic pc, input logic [7:0] v);
        @(posedge clk) power_control_we <= pc;
        memory_config_we <= !pc;
        power_control_wdata <= v;
        memory_config_wdata <= v;
        @(posedge clk) power_control_we <= 1'h0;
        memory_config_we <= 1'h0;
        @(negedge clk);
    endtask
    task sp_op(input logic pu, input logic po, input logic we, input logic hwe, input logic [7:0] v);
        @(posedge clk) stack_push <= pu;
        stack_pop <= po;
        stack_top_pointer_we <= we;
        stack_pointer_high_we <= hwe;
        stack_top_pointer_wdata <= v;
        stack_pointer_high_wdata <= v;
        @(posedge clk) {stack_push, stack_pop, stack_top_pointer_we, stack_pointer_high_we} <= 4'h0;
        repeat (2) @(negedge clk);
    endtask

    task t_start;
        do_reset(1'h1, 1'h1);
        chk("exec_external", 0, exec_external);
        chk("serial_download", 0, serial_download_mode);
        chk("stack_pointer", 8'h07, stack_top_pointer);
        chk("config", 8'h00, memory_config_reg);
        @(posedge clk) low_port_latch <= 8'h0f;
        @(posedge clk) low_port_latch <= 8'hff;
        @(negedge clk) chk("low_port_oe", 8'hf0, low_port_oe);
    endtask
    task t_fetch;
        logic [15:0] a [4] = '{16'h1234, 16'hf7ff, 16'hf800, 16'hffff};
        foreach (a[i]) begin
            code_rd(a[i]);
            chk("code_from_flash", a[i] < 16'hf800, f);
            if (a[i] >= 16'hf800) chk("code_data", 8'h00, d);
        end
    endtask
    task t_ram;
        ram_chk(MMD_RAM_DIRECT, 8'h7f, 2'h0, 8'h7f, 1'h0, 3'h0);
        ram_chk(MMD_RAM_DIRECT, 8'h80, 2'h0, 8'h00, 1'h1, 3'h0);
        ram_chk(MMD_RAM_INDIRECT, 8'hff, 2'h0, 8'hff, 1'h0, 3'h0);
        ram_chk(MMD_RAM_BANKREG, 8'h05, 2'h3, 8'h1d, 1'h0, 3'h0);
        ram_chk(MMD_RAM_BIT, 8'h7f, 2'h0, 8'h2f, 1'h0, 3'h7);
        ram_chk(MMD_RAM_BIT, 8'h00, 2'h0, 8'h20, 1'h0, 3'h0);
    endtask
    task t_stack;
        sp_op(1'h1, 1'h0, 1'h0, 1'h0, 8'h00);
        chk("stack_addr", 11'h008, stack_addr);
        sp_op(1'h0, 1'h0, 1'h1, 1'h1, 8'hff);
        sp_op(1'h1, 1'h0, 1'h0, 1'h0, 8'h00);
        chk("sp_wrap", 8'h00, stack_top_pointer);
        chk("sph_locked", 8'h00, stack_pointer_high);
        cfg_wr(1'h0, 8'h80);
        sp_op(1'h0, 1'h0, 1'h1, 1'h0, 8'hff);
        sp_op(1'h1, 1'h0, 1'h0, 1'h0, 8'h00);
        chk("ext_addr", 11'h100, stack_addr);
        chk("in_extended_data_ram", 1, stack_in_extended_data_ram);
        sp_op(1'h0, 1'h1, 1'h0, 1'h0, 8'h00);
        chk("ext_pop", 8'hff, stack_top_pointer);
        sp_op(1'h0, 1'h0, 1'h0, 1'h1, 8'h05);
        chk("sph_write", 8'h05, stack_pointer_high);
    endtask
    task t_data;
        cfg_wr(1'h0, 8'h01);
        data_acc(1'h0, 24'h0007ff, 8'h00, 1'h1);
        data_acc(1'h0, 24'h000800, 8'h00, 1'h0);
        data_acc(1'h1, 24'h123456, 8'h6b, 1'h0);
        chk("wr_addr", 24'h123456, mem.wr_addr);
        chk("wr_data", 8'h6b, mem.wr_data);
        cfg_wr(1'h0, 8'h00);
        data_acc(1'h0, 24'h000010, 8'h00, 1'h0);
    endtask
    task t_ext;
        do_reset(1'h0, 1'h1);
        chk("exec_external", 1, exec_external);
        c0 = ale_cnt;
        code_rd(16'h5a3c);
        chk("ext_code", pat(24'h005a3c), d);
        chk("fetch_ale", 1, ale_cnt - c0);
        cfg_wr(1'h1, 8'h10);
        c0 = ale_cnt;
        code_rd(16'h0100);
        chk("ale_off", 0, ale_cnt - c0);
        do_reset(1'h1, 1'h0);
        chk("serial_download", 1, serial_download_mode);
    endtask

    initial begin
        #1000000;
        miscompares++;
        print_verdict();
    end
    initial begin
        t_start();
        t_fetch();
        t_ram();
        t_stack();
        t_data();
        t_ext();
        print_verdict();
    end
endmodule
